// ### src/uil_pkg.sv
// uart interrupt identification and line format: shared constants and types
// assumes a single 25 MHz system clock and an AXI4-Lite master on the register port
`default_nettype none

package uil_pkg;

    // register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_ISR = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_LCR = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_IER = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_DIV = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_EFR = 5'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // line_control fields and the efr enhanced enable
    localparam int LCR_DLAB = 7;
    localparam int LCR_BRK = 6;
    localparam int LCR_FORCE = 5;
    localparam int LCR_EVEN = 4;
    localparam int LCR_PEN = 3;
    localparam int LCR_STOP = 2;
    localparam int EFR_ENH = 4;

    // reset values
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [7:0] EFR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;

    // interrupt sources, index order is priority order
    localparam int NSRC = 7;
    localparam logic [2:0] SRC_LSR = 3'h0;
    localparam logic [2:0] SRC_RXAV = 3'h1;
    localparam logic [2:0] SRC_RXTO = 3'h2;
    localparam logic [2:0] SRC_THRE = 3'h3;
    localparam logic [2:0] SRC_MODEM = 3'h4;
    localparam logic [2:0] SRC_XOFF = 3'h5;
    localparam logic [2:0] SRC_FLOW = 3'h6;
    localparam logic [NSRC-1:0] IER_RST = 7'h00;

    localparam logic [5:0] CODE_LSR = 6'h06;
    localparam logic [5:0] CODE_RXAV = 6'h04;
    localparam logic [5:0] CODE_RXTO = 6'h0c;
    localparam logic [5:0] CODE_THRE = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;

    localparam logic [3:0] WL_BASE = 4'h5;
    typedef enum logic [2:0] {PAR_NONE = 3'h0, PAR_ODD = 3'h1, PAR_EVEN = 3'h2,
                              PAR_ONE = 3'h3, PAR_ZERO = 3'h4} uil_par_t;
    // stop length counted in half bit times
    localparam logic [2:0] STOP_1 = 3'h2;
    localparam logic [2:0] STOP_1H = 3'h3;
    localparam logic [2:0] STOP_2 = 3'h4;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } uil_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } uil_axi_rsp_t;

    // one-cycle event pulses from the rest of the channel
    typedef struct packed {
        logic lsr_err;
        logic rx_timeout;
        logic thr_empty;
        logic modem_chg;
        logic xoff_det;
        logic xon_det;
        logic flow_chg;
    } uil_src_t;

    typedef struct packed {
        logic [3:0] data_bits;
        logic [2:0] stop_half;
        uil_par_t par;
    } uil_fmt_t;

    function automatic logic [5:0] src_code(input logic [2:0] idx);
        case (idx)
            SRC_LSR: src_code = CODE_LSR;
            SRC_RXAV: src_code = CODE_RXAV;
            SRC_RXTO: src_code = CODE_RXTO;
            SRC_THRE: src_code = CODE_THRE;
            SRC_XOFF: src_code = CODE_XOFF;
            SRC_FLOW: src_code = CODE_FLOW;
            default: src_code = CODE_MODEM;
        endcase
    endfunction

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'h0: trig_level = 5'h01;
            2'h1: trig_level = 5'h04;
            2'h2: trig_level = 5'h08;
            default: trig_level = 5'h0e;
        endcase
    endfunction

endpackage

`default_nettype wire

// ### src/uil_int_arb.sv
// fixed-priority pick among pending interrupt sources
// assumes index 0 is the most urgent; purely combinational, clock only for checks
`default_nettype none

module uil_int_arb #(
    parameter int NSRC = uil_pkg::NSRC
) (
    // check clock
    input wire logic clk_sys,
    input wire logic rstn,
    // sources
    input wire logic [NSRC-1:0] pend,
    // pick
    output logic found,
    output logic [2:0] idx
);

    always_comb begin
        found = 1'b0;
        idx = 3'h0;
        // walk down so the lowest pending index is left standing
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                found = 1'b1;
                idx = 3'(i);
            end
        end
    end

    AST_ARB_LOWEST: assert property (@(posedge clk_sys) disable iff (!rstn)
        found |-> (pend[idx] && ((pend & ((NSRC'(1) << idx) - NSRC'(1))) == '0)))
        else $error("arbiter did not pick the most urgent source");
    AST_ARB_FOUND: assert property (@(posedge clk_sys) disable iff (!rstn)
        found == (|pend))
        else $error("arbiter found flag disagrees with pending set");

endmodule

`default_nettype wire

// ### src/uil_fmt.sv
// character format decode and break forcing of the serial output
// assumes the transmit shifter supplies tx_bit and uses fmt for framing
`default_nettype none

module uil_fmt (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control
    input wire logic [7:0] line_control,
    input wire logic tx_bit,
    // results
    output logic tx_out,
    output uil_pkg::uil_fmt_t fmt
);

    logic tx_d;
    uil_pkg::uil_fmt_t fmt_d;

    always_comb begin
        tx_d = line_control[uil_pkg::LCR_BRK] ? 1'b0 : tx_bit;
        fmt_d.data_bits = uil_pkg::WL_BASE + {2'h0, line_control[1:0]};
        if (!line_control[uil_pkg::LCR_STOP]) begin
            fmt_d.stop_half = uil_pkg::STOP_1;
        end else if (line_control[1:0] == 2'h0) begin
            fmt_d.stop_half = uil_pkg::STOP_1H;
        end else begin
            fmt_d.stop_half = uil_pkg::STOP_2;
        end
        if (!line_control[uil_pkg::LCR_PEN]) begin
            fmt_d.par = uil_pkg::PAR_NONE;
        end else if (line_control[uil_pkg::LCR_FORCE]) begin
            // forced level is the inverse of the even-select bit
            fmt_d.par = line_control[uil_pkg::LCR_EVEN] ? uil_pkg::PAR_ZERO : uil_pkg::PAR_ONE;
        end else begin
            fmt_d.par = line_control[uil_pkg::LCR_EVEN] ? uil_pkg::PAR_EVEN : uil_pkg::PAR_ODD;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_out <= 1'b1;
            fmt <= '{data_bits: uil_pkg::WL_BASE, stop_half: uil_pkg::STOP_1, par: uil_pkg::PAR_NONE};
        end else begin
            tx_out <= tx_d;
            fmt <= fmt_d;
        end
    end

    AST_BREAK_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)
        line_control[uil_pkg::LCR_BRK] [*2] |-> !tx_out)
        else $error("serial output not held low during break");
    AST_FORCED_PAR: assert property (@(posedge clk_sys) disable iff (!rstn)
        (line_control[uil_pkg::LCR_PEN] && line_control[uil_pkg::LCR_FORCE]) |=>
        (fmt.par == ($past(line_control[uil_pkg::LCR_EVEN]) ? uil_pkg::PAR_ZERO : uil_pkg::PAR_ONE)))
        else $error("forced parity level wrong");
    AST_STOP_LEN: assert property (@(posedge clk_sys) disable iff (!rstn)
        (line_control[uil_pkg::LCR_STOP] && line_control[1:0] == 2'h0) |=> fmt.stop_half == uil_pkg::STOP_1H)
        else $error("five-bit long stop not one and a half");

endmodule

`default_nettype wire

// ### src/uil_top.sv
// interrupt identification, line control and register slave of one uart channel
// assumes source events are one-cycle pulses synchronous to clk_sys and an AXI4-Lite master
//
// Contract
// - report most urgent of six levels on read; code returns the source latched earlier, not a more urgent later one
// - read clears only the reported source
// - reported source held until serviced or until its enabled pending bit clears
// - line status: level 1, code 000110
// - data available: level 2, code 000100
// - receive timeout: level 2, code 001100
// - holding empty: level 3, code 000010
// - modem change: level 4, code 000000
// - xoff or special char: level 5, 010000
// - cts/rts change: level 6, 100000
// - bits 7:6 mirror fifo enable, reset 0
// - bits 5:4 only with enhanced enable
// - xoff bit sticks until xon received
// - bit 0 low when pending, reset 1
// - line control bit 7 opens divisor, enhanced
// - bit 6 forces transmit output low
// - forced parity: one if bit4=0, else zero
// - bit 3 parity enable, bit 4 even
// - bits 1:0 give 5 to 8 bits
// - bit 2 gives 1, 1.5 or 2 stops
// - fifo data interrupt at trigger count
`default_nettype none

module uil_top #(
    parameter int CNT_W = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register bus
    input wire uil_pkg::uil_axi_req_t axi_req,
    output uil_pkg::uil_axi_rsp_t axi_rsp,
    // interrupt sources
    input wire uil_pkg::uil_src_t src,
    input wire logic fifo_en,
    input wire logic [1:0] fifo_trig_sel,
    input wire logic [CNT_W-1:0] rx_count,
    // serial side
    input wire logic tx_bit,
    output logic tx_out,
    output uil_pkg::uil_fmt_t fmt,
    output logic [15:0] divisor,
    // interrupt
    output logic int_out
);

    localparam int NSRC = uil_pkg::NSRC;

    uil_pkg::uil_axi_rsp_t rsp_q, rsp_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [uil_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [7:0] lcr_q, lcr_d;
    logic [7:0] efr_q, efr_d;
    logic [15:0] div_q, div_d;
    logic [NSRC-1:0] ier_q, ier_d;
    logic [NSRC-1:0] pend_q, pend_d;
    logic cur_valid_q, cur_valid_d;
    logic [2:0] cur_idx_q, cur_idx_d;
    logic fifo_en_q;
    logic int_q, int_d;
    logic [NSRC-1:0] eff_q, eff_d;
    logic arb_found;
    logic [2:0] arb_idx;
    logic aw_take, w_take, ar_take, isr_rd;
    logic rxav_cond;
    logic [7:0] isr_val;

    // sources 5 and 6 only exist with the enhanced enable set
    function automatic logic [NSRC-1:0] eff_mask(input logic [NSRC-1:0] p, input logic [NSRC-1:0] en,
                                                 input logic enh);
        logic [NSRC-1:0] m;
        m = p & en;
        m[uil_pkg::SRC_XOFF] = m[uil_pkg::SRC_XOFF] & enh;
        m[uil_pkg::SRC_FLOW] = m[uil_pkg::SRC_FLOW] & enh;
        return m;
    endfunction

    function automatic logic mapped(input logic [uil_pkg::ADDR_W-1:0] a, input logic dlab);
        case (a)
            uil_pkg::OFF_ISR, uil_pkg::OFF_LCR, uil_pkg::OFF_IER: mapped = 1'b1;
            uil_pkg::OFF_DIV, uil_pkg::OFF_EFR: mapped = dlab;
            default: mapped = 1'b0;
        endcase
    endfunction

    assign eff_q = eff_mask(pend_q, ier_q, efr_q[uil_pkg::EFR_ENH]);

    uil_int_arb #(
        .NSRC(NSRC)
    ) u_arb (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pend(eff_q),
        .found(arb_found),
        .idx(arb_idx)
    );

    uil_fmt u_fmt (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .line_control(lcr_q),
        .tx_bit(tx_bit),
        .tx_out(tx_out),
        .fmt(fmt)
    );

    // status byte as seen by a read in this cycle
    always_comb begin
        isr_val = {{2{fifo_en_q}}, 6'h01};
        if (cur_valid_q) begin
            isr_val[5:0] = uil_pkg::src_code(cur_idx_q);
        end
    end

    // in fifo mode the data interrupt fires at the trigger count only
    assign rxav_cond = fifo_en_q ? (rx_count == CNT_W'(uil_pkg::trig_level(fifo_trig_sel)))
                                 : (rx_count != '0);

    assign aw_take = axi_req.awvalid && rsp_q.awready;
    assign w_take = axi_req.wvalid && rsp_q.wready;
    assign ar_take = axi_req.arvalid && rsp_q.arready;
    assign isr_rd = ar_take && axi_req.araddr == uil_pkg::OFF_ISR && cur_valid_q;

    always_comb begin
        rsp_d = rsp_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        lcr_d = lcr_q;
        efr_d = efr_q;
        div_d = div_q;
        ier_d = ier_q;
        pend_d = pend_q;
        cur_valid_d = cur_valid_q;
        cur_idx_d = cur_idx_q;

        // write path: address and data in either order
        if (aw_take) begin
            aw_have_d = 1'b1;
            awaddr_d = axi_req.awaddr;
        end
        if (w_take) begin
            w_have_d = 1'b1;
            wdata_d = axi_req.wdata;
            wstrb_d = axi_req.wstrb;
        end
        if (rsp_q.bvalid && axi_req.bready) begin
            rsp_d.bvalid = 1'b0;
        end
        if (aw_have_q && w_have_q && !rsp_q.bvalid) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            rsp_d.bvalid = 1'b1;
            rsp_d.bresp = mapped(awaddr_q, lcr_q[uil_pkg::LCR_DLAB]) ? uil_pkg::RESP_OKAY
                                                                     : uil_pkg::RESP_SLVERR;
            if (wstrb_q[0]) begin
                case (awaddr_q)
                    uil_pkg::OFF_LCR: lcr_d = wdata_q[7:0];
                    uil_pkg::OFF_IER: ier_d = wdata_q[NSRC-1:0];
                    uil_pkg::OFF_EFR: begin
                        if (lcr_q[uil_pkg::LCR_DLAB]) begin
                            efr_d = wdata_q[7:0];
                        end
                    end
                    default: ;
                endcase
            end
            if (awaddr_q == uil_pkg::OFF_DIV && lcr_q[uil_pkg::LCR_DLAB]) begin
                for (int b = 0; b < 2; b++) begin
                    if (wstrb_q[b]) begin
                        div_d[b*8 +: 8] = wdata_q[b*8 +: 8];
                    end
                end
            end
        end

        // read path: one outstanding, data registered with the accept
        if (rsp_q.rvalid && axi_req.rready) begin
            rsp_d.rvalid = 1'b0;
        end
        if (ar_take) begin
            rsp_d.rvalid = 1'b1;
            rsp_d.rresp = mapped(axi_req.araddr, lcr_q[uil_pkg::LCR_DLAB]) ? uil_pkg::RESP_OKAY
                                                                           : uil_pkg::RESP_SLVERR;
            rsp_d.rdata = 32'h0000_0000;
            case (axi_req.araddr)
                uil_pkg::OFF_ISR: rsp_d.rdata[7:0] = isr_val;
                uil_pkg::OFF_LCR: rsp_d.rdata[7:0] = lcr_q;
                uil_pkg::OFF_IER: rsp_d.rdata[NSRC-1:0] = ier_q;
                uil_pkg::OFF_DIV: begin
                    if (lcr_q[uil_pkg::LCR_DLAB]) begin
                        rsp_d.rdata[15:0] = div_q;
                    end
                end
                uil_pkg::OFF_EFR: begin
                    if (lcr_q[uil_pkg::LCR_DLAB]) begin
                        rsp_d.rdata[7:0] = efr_q;
                    end
                end
                default: ;
            endcase
        end

        // clears first so that a same-cycle event sets again
        if (isr_rd) begin
            cur_valid_d = 1'b0;
            if (cur_idx_q != uil_pkg::SRC_XOFF) begin
                pend_d[cur_idx_q] = 1'b0;
            end
        end
        if (src.xon_det) begin
            pend_d[uil_pkg::SRC_XOFF] = 1'b0;
        end
        if (src.lsr_err) pend_d[uil_pkg::SRC_LSR] = 1'b1;
        if (rxav_cond) pend_d[uil_pkg::SRC_RXAV] = 1'b1;
        if (src.rx_timeout) pend_d[uil_pkg::SRC_RXTO] = 1'b1;
        if (src.thr_empty) pend_d[uil_pkg::SRC_THRE] = 1'b1;
        if (src.modem_chg) pend_d[uil_pkg::SRC_MODEM] = 1'b1;
        if (src.xoff_det) pend_d[uil_pkg::SRC_XOFF] = 1'b1;
        if (src.flow_chg) pend_d[uil_pkg::SRC_FLOW] = 1'b1;

        // the reported source stays put until read or withdrawn
        if (cur_valid_q && !eff_q[cur_idx_q]) begin
            cur_valid_d = 1'b0;
        end
        if (!cur_valid_q && arb_found) begin
            cur_valid_d = 1'b1;
            cur_idx_d = arb_idx;
        end

        rsp_d.awready = !aw_have_d && !rsp_d.bvalid;
        rsp_d.wready = !w_have_d && !rsp_d.bvalid;
        rsp_d.arready = !rsp_d.rvalid;
    end

    assign eff_d = eff_mask(pend_d, ier_d, efr_d[uil_pkg::EFR_ENH]);
    assign int_d = |eff_d;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rsp_q <= '0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            lcr_q <= uil_pkg::LCR_RST;
            efr_q <= uil_pkg::EFR_RST;
            div_q <= uil_pkg::DIV_RST;
            ier_q <= uil_pkg::IER_RST;
            pend_q <= '0;
            cur_valid_q <= 1'b0;
            cur_idx_q <= 3'h0;
            fifo_en_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            rsp_q <= rsp_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            lcr_q <= lcr_d;
            efr_q <= efr_d;
            div_q <= div_d;
            ier_q <= ier_d;
            pend_q <= pend_d;
            cur_valid_q <= cur_valid_d;
            cur_idx_q <= cur_idx_d;
            fifo_en_q <= fifo_en;
            int_q <= int_d;
        end
    end

    assign axi_rsp = rsp_q;
    assign divisor = div_q;
    assign int_out = int_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_isr_read;
        ar_take && axi_req.araddr == uil_pkg::OFF_ISR;
    endsequence

    sequence s_serviced;
        isr_rd;
    endsequence

    AST_ISR_CODE: assert property ((s_isr_read and cur_valid_q) |=>
        rsp_q.rdata[5:0] == uil_pkg::src_code($past(cur_idx_q)))
        else $error("status code does not match reported source");
    AST_IDLE_BIT: assert property (s_isr_read |=> rsp_q.rdata[0] == !$past(cur_valid_q))
        else $error("status bit 0 wrong");
    AST_FIFO_BITS: assert property (s_isr_read |=> rsp_q.rdata[7:6] == {2{$past(fifo_en_q)}})
        else $error("fifo enabled bits wrong");
    AST_READ_DROPS: assert property (s_serviced |=> !cur_valid_q)
        else $error("serviced source still reported");
    AST_HOLD_CUR: assert property ((cur_valid_q && !isr_rd && eff_q[cur_idx_q]) |=>
        (cur_valid_q && cur_idx_q == $past(cur_idx_q)))
        else $error("reported source replaced before service");
    AST_XOFF_STICKY: assert property ((pend_q[uil_pkg::SRC_XOFF] && !src.xon_det) |=>
        pend_q[uil_pkg::SRC_XOFF])
        else $error("xoff bit dropped without xon");
    AST_ENH_GATE: assert property (!efr_q[uil_pkg::EFR_ENH] [*2] |->
        !(cur_valid_q && cur_idx_q >= uil_pkg::SRC_XOFF))
        else $error("enhanced source reported while disabled");
    AST_INT_OUT: assert property ((|eff_q) [*2] |-> int_out)
        else $error("interrupt output low with enabled pending");
    AST_DIV_GATE: assert property ((aw_have_q && w_have_q && !rsp_q.bvalid && !lcr_q[uil_pkg::LCR_DLAB])
        |=> $stable(div_q))
        else $error("divisor written with latch access closed");

endmodule

`default_nettype wire

// ### dv/uil_host.sv
// axi4-lite host model for the register port
// assumes the bench runs one write or one read at a time
`default_nettype none
module uil_host (
    // clock
    input wire logic clk_sys,
    // bus
    output var uil_pkg::uil_axi_req_t axi_req,
    input wire uil_pkg::uil_axi_rsp_t axi_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial axi_req = '0;
    // handshakes are judged mid-cycle, where the values seen are those the next edge samples
    task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_sys);
        axi_req.awaddr <= a;
        axi_req.wdata <= v;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        while (!b) begin
            @(negedge clk_sys);
            aw = axi_req.awvalid && axi_rsp.awready;
            w = axi_req.wvalid && axi_rsp.wready;
            b = axi_rsp.bvalid === 1'b1;
            r = axi_rsp.bresp;
            @(posedge clk_sys);
            if (aw) axi_req.awvalid <= 1'b0;
            if (w) axi_req.wvalid <= 1'b0;
            if (b) axi_req.bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar, b;
        b = 1'b0;
        @(posedge clk_sys);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        while (!b) begin
            @(negedge clk_sys);
            ar = axi_req.arvalid && axi_rsp.arready;
            b = axi_rsp.rvalid === 1'b1;
            v = axi_rsp.rdata;
            r = axi_rsp.rresp;
            @(posedge clk_sys);
            if (ar) axi_req.arvalid <= 1'b0;
            if (b) axi_req.rready <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### dv/uart_int_id_line_format_tb_top.sv
// bench: status priority reads, line control decode and break against a queue-free model
// assumes uil_host as bus master, reset offsets from uil_pkg
`default_nettype none
module uart_int_id_line_format_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0;
    logic rstn = 0;
    uil_pkg::uil_axi_req_t axi_req;
    uil_pkg::uil_axi_rsp_t axi_rsp;
    uil_pkg::uil_src_t src = '0;
    logic fifo_en = 0;
    logic [1:0] fifo_trig_sel = 0;
    logic [4:0] rx_count = 0;
    logic tx_bit = 1;
    logic tx_out, int_out;
    uil_pkg::uil_fmt_t fmt;
    logic [15:0] divisor;
    logic [31:0] d;
    logic [1:0] r;
    int fail_count = 0, checked = 0, cyc = 0;
    int pend[7], ier, enh, cur = 7;
    int code[7] = '{6, 4, 12, 2, 0, 16, 32};
    int trg[4] = '{1, 4, 8, 14};
    uil_top #(.CNT_W(5)) uut (.clk_sys(clk_sys), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .src(src), .fifo_en(fifo_en), .fifo_trig_sel(fifo_trig_sel), .rx_count(rx_count),
        .tx_bit(tx_bit), .tx_out(tx_out), .fmt(fmt), .divisor(divisor), .int_out(int_out));
    uil_host host (.clk_sys(clk_sys), .axi_req(axi_req), .axi_rsp(axi_rsp));
    always #20 clk_sys = ~clk_sys;
    function automatic int en(int i);
        return pend[i] != 0 && ier[i] && (i < 5 || enh != 0);
    endfunction
    // reported source is latched: only a withdrawn one gives way before its read
    function automatic void upd();
        if (cur < 7 && !en(cur)) cur = 7;
        if (cur == 7) begin
            for (int i = 6; i >= 0; i--)
                if (en(i)) cur = i;
        end
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wreg(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
        host.wr(a, v, r);
        chk("bresp", er, r);
    endtask
    task automatic rreg(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
        host.rd(a, d, r);
        chk("rresp", er, r);
        chk("rdata", v, d);
    endtask
    task automatic ev(input logic [6:0] m);
        @(posedge clk_sys);
        src <= m;
        @(posedge clk_sys);
        src <= '0;
        if (m[6]) pend[0] = 1;
        if (m[5]) pend[2] = 1;
        if (m[4]) pend[3] = 1;
        if (m[3]) pend[4] = 1;
        if (m[2]) pend[5] = 1;
        if (m[1]) pend[5] = 0;
        if (m[0]) pend[6] = 1;
        upd();
        tick(2);
    endtask
    task automatic rs(output int e);
        e = cur == 7 ? {fifo_en, fifo_en, 6'h01} : {fifo_en, fifo_en, 6'(code[cur])};
        chk("int_out", cur != 7, int_out);
        host.rd(uil_pkg::OFF_ISR, d, r);
        chk("status", e, d);
        if (cur < 7 && cur != 5) pend[cur] = 0;
        cur = 7;
        upd();
        tick(2);
    endtask
    task automatic drain();
        int e;
        e = 0;
        while (!e[0]) rs(e);
    endtask
    task automatic summarize();
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        int e, p;
        logic [7:0] l;
        void'($urandom(31499));
        tick(6);
        rstn <= 1'b1;
        rs(e);
        rreg(uil_pkg::OFF_LCR, 0, 2'h0);
        wreg(uil_pkg::OFF_IER, 32'h7f, 2'h0);
        ier = 'h7f;
        ev(7'h79);
        drain();
        ev(7'h10);
        ev(7'h40);
        drain();
        rreg(uil_pkg::OFF_EFR, 0, 2'h2);
        wreg(uil_pkg::OFF_LCR, 32'h80, 2'h0);
        rreg(uil_pkg::OFF_DIV, 1, 2'h0);
        wreg(uil_pkg::OFF_DIV, 32'h1234, 2'h0);
        chk("divisor", 16'h1234, divisor);
        rreg(5'h14, 0, 2'h2);
        wreg(uil_pkg::OFF_EFR, 32'h10, 2'h0);
        wreg(uil_pkg::OFF_LCR, 32'h00, 2'h0);
        enh = 1;
        upd();
        drain();
        ev(7'h04);
        rs(e);
        rs(e);
        ev(7'h02);
        rs(e);
        fifo_en <= 1'b1;
        // the design registers fifo_en: let it settle before a nonzero count arrives
        tick(2);
        for (int t = 0; t < 4; t++) begin
            fifo_trig_sel <= 2'(t);
            rx_count <= 5'(trg[t] + 1);
            tick(3);
            rs(e);
            rx_count <= 5'(trg[t]);
            tick(3);
            rx_count <= 5'h00;
            pend[1] = 1;
            upd();
            tick(3);
            drain();
        end
        fifo_en <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            l = 8'($urandom());
            tx_bit <= 1'(k);
            wreg(uil_pkg::OFF_LCR, {24'h0, l}, 2'h0);
            tick(2);
            rreg(uil_pkg::OFF_LCR, {24'h0, l}, 2'h0);
            p = l[3] ? (l[5] ? 3 + l[4] : 1 + l[4]) : 0;
            chk("par", p, fmt.par);
            chk("bits", 5 + l[1:0], fmt.data_bits);
            chk("stop", l[2] ? (l[1:0] == 0 ? 3 : 4) : 2, fmt.stop_half);
            chk("tx_out", l[6] ? 0 : k % 2, tx_out);
        end
        summarize();
    end
endmodule
`default_nettype wire
